//--- rtl/decade_carry_decode.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------------
// Terminal count decode for the rippling cascade carry
// ---------------------------------------------------------------------
// Kept combinational on purpose: a cascade of stages on one clock needs
// the carry to settle within the same cycle, so this path cannot be
// registered without breaking multi-stage counting.
module decade_carry_decode (
   input  wire logic [3:0] count,       // Present counter state
   input  wire logic       dir_down,    // High while counting down
   input  wire logic       carry_in_n,  // Stage enable, active low
   output logic            carry_out_n  // Terminal count, active low
);

   logic at_nine;
   logic at_zero;
   logic terminal;

   // All four bits enter directly, so a preset value shows at once
   always_comb begin
      at_nine  = count[3] & ~count[2] & ~count[1] & count[0];
      at_zero  = ~count[3] & ~count[2] & ~count[1] & ~count[0];
      terminal = dir_down ? at_zero : at_nine;
      carry_out_n = ~(terminal & ~carry_in_n);
   end

endmodule : decade_carry_decode

`default_nettype wire

//--- rtl/decade_pkg.sv
package decade_pkg;

   // ------------------------------------------------------------------
   // Counter geometry and fixed values
   // ------------------------------------------------------------------
   localparam int unsigned CNT_W     = 4;
   localparam logic [3:0]  CNT_ZERO  = 4'h0;   // Lowest decimal value
   localparam logic [3:0]  CNT_NINE  = 4'h9;   // Highest decimal value
   localparam logic [3:0]  CNT_STEP  = 4'h1;   // Increment and decrement
   localparam logic [3:0]  CNT_RESET = 4'h0;   // Value after SRST

   // ------------------------------------------------------------------
   // Operating modes, coded as {select_a, select_b}
   // ------------------------------------------------------------------
   // The select pins already form a Gray path: preset, up, hold, down.
   typedef enum logic [1:0] {
      MODE_PRESET = 2'h0,
      MODE_UP     = 2'h1,
      MODE_HOLD   = 2'h3,
      MODE_DOWN   = 2'h2
   } mode_t;

   // Decode of the two select lines, shared by logic and checks
   function automatic mode_t decode_mode(input logic sel_a,
                                         input logic sel_b);
      mode_t m;
      m = MODE_HOLD;
      case ({sel_a, sel_b})
         2'h0:    m = MODE_PRESET;
         2'h1:    m = MODE_UP;
         2'h2:    m = MODE_DOWN;
         2'h3:    m = MODE_HOLD;
         default: m = MODE_HOLD;
      endcase
      return m;
   endfunction : decode_mode

endpackage : decade_pkg

//--- rtl/sync_updown_decade_counter.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Selects pick preset, up, down, hold
// - Preset loads data only on clock edge
// - Carry input kept out of mode choice, which uses the selects alone
// - Carry output low at terminal count while carry input active
// - Carry output decoded directly from count bits
// - State changes only on rising clock edge
// - Count runs zero to nine, wrapping both ways
// - Inactive carry input blocks up/down counting
module sync_updown_decade_counter (
   input  wire logic CLK_SYS,              // System clock, 10 MHz
   input  wire logic SRST,                 // Synchronous reset, high
   input  wire logic FUNCTION_SELECT_A,    // Mode select, first line
   input  wire logic FUNCTION_SELECT_B,    // Mode select, second line
   input  wire logic PRESET_BIT_ZERO,      // Preset data, bit 0
   input  wire logic PRESET_BIT_ONE,       // Preset data, bit 1
   input  wire logic PRESET_BIT_TWO,       // Preset data, bit 2
   input  wire logic PRESET_BIT_THREE,     // Preset data, bit 3
   input  wire logic CARRY_IN_N,           // Count enable, active low
   output logic      COUNT_BIT_ZERO,       // Count, bit 0
   output logic      COUNT_BIT_ONE,        // Count, bit 1
   output logic      COUNT_BIT_TWO,        // Count, bit 2
   output logic      COUNT_BIT_THREE,      // Count, bit 3
   output logic      CARRY_OUT_N           // Terminal count, active low
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   decade_pkg::mode_t mode_now;
   logic [3:0]        preset_word;
   logic [3:0]        count_reg;
   logic [3:0]        count_next;
   logic              count_enable;
   logic              dir_down;

   // ------------------------------------------------------------------
   // Input gathering and mode decode
   // ------------------------------------------------------------------
   // Selects and carry are sampled only at the edge, so the host may
   // move them freely between edges without disturbing the count.
   always_comb begin
      preset_word = {PRESET_BIT_THREE, PRESET_BIT_TWO,
                     PRESET_BIT_ONE, PRESET_BIT_ZERO};
      mode_now = decade_pkg::decode_mode(FUNCTION_SELECT_A,
                                         FUNCTION_SELECT_B);
      dir_down = (mode_now == decade_pkg::MODE_DOWN);
      // Carry gates the counting modes only; preset and hold ignore it
      count_enable = ~CARRY_IN_N;
   end

   // ------------------------------------------------------------------
   // Next count
   // ------------------------------------------------------------------
   // Values ten to fifteen are left in one edge whatever the direction,
   // trading a slightly odd path for the fastest possible recovery.
   always_comb begin
      count_next = count_reg;
      case (mode_now)
         decade_pkg::MODE_PRESET: begin
            count_next = preset_word;
         end
         decade_pkg::MODE_UP: begin
            if (count_enable) begin
               if (count_reg >= decade_pkg::CNT_NINE) begin
                  count_next = decade_pkg::CNT_ZERO;
               end else begin
                  count_next = count_reg + decade_pkg::CNT_STEP;
               end
            end
         end
         decade_pkg::MODE_DOWN: begin
            if (count_enable) begin
               if (count_reg == decade_pkg::CNT_ZERO) begin
                  count_next = decade_pkg::CNT_NINE;
               end else if (count_reg > decade_pkg::CNT_NINE) begin
                  count_next = decade_pkg::CNT_NINE;
               end else begin
                  count_next = count_reg - decade_pkg::CNT_STEP;
               end
            end
         end
         decade_pkg::MODE_HOLD: begin
            count_next = count_reg;
         end
         default: begin
            count_next = count_reg;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Count register
   // ------------------------------------------------------------------
   // The only storage: everything changes on the rising edge alone.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         count_reg <= decade_pkg::CNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   // Count outputs are the register bits themselves
   always_comb begin
      COUNT_BIT_ZERO  = count_reg[0];
      COUNT_BIT_ONE   = count_reg[1];
      COUNT_BIT_TWO   = count_reg[2];
      COUNT_BIT_THREE = count_reg[3];
   end

   // ------------------------------------------------------------------
   // Cascade carry
   // ------------------------------------------------------------------
   // Only output not taken from a flop: the carry must ripple between
   // stages within one cycle, so a register here would skip counts.
   decade_carry_decode u_carry (
      .count       (count_reg),
      .dir_down    (dir_down),
      .carry_in_n  (CARRY_IN_N),
      .carry_out_n (CARRY_OUT_N)
   );

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb_sys @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);

   // Hold keeps the count whatever the carry does
   property p_hold_keeps;
      (mode_now == decade_pkg::MODE_HOLD) |=> $stable(count_reg);
   endproperty
   a_hold_keeps: assert property (p_hold_keeps)
      else $error("Count moved in hold mode");

   // Preset loads the sampled data word at the edge
   property p_preset_load;
      (mode_now == decade_pkg::MODE_PRESET)
         |=> (count_reg == $past(preset_word));
   endproperty
   a_preset_load: assert property (p_preset_load)
      else $error("Preset did not load the data inputs");

   // Up by one inside the decimal range
   property p_count_up;
      (mode_now == decade_pkg::MODE_UP && !CARRY_IN_N
         && count_reg < decade_pkg::CNT_NINE)
         |=> (count_reg == $past(count_reg) + decade_pkg::CNT_STEP);
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("Count up did not advance by one");

   // Down by one inside the decimal range
   property p_count_down;
      (mode_now == decade_pkg::MODE_DOWN && !CARRY_IN_N
         && count_reg != decade_pkg::CNT_ZERO
         && count_reg <= decade_pkg::CNT_NINE)
         |=> (count_reg == $past(count_reg) - decade_pkg::CNT_STEP);
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("Count down did not retreat by one");

   // Wrap in both directions
   property p_wrap;
      (!CARRY_IN_N && ((mode_now == decade_pkg::MODE_UP
         && count_reg == decade_pkg::CNT_NINE)
         || (mode_now == decade_pkg::MODE_DOWN
         && count_reg == decade_pkg::CNT_ZERO)))
         |=> (count_reg == ($past(dir_down) ? decade_pkg::CNT_NINE
                                             : decade_pkg::CNT_ZERO));
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Decimal wrap went wrong");

   // Inactive carry freezes counting modes
   property p_carry_gates;
      (CARRY_IN_N && (mode_now == decade_pkg::MODE_UP
         || mode_now == decade_pkg::MODE_DOWN)) |=> $stable(count_reg);
   endproperty
   a_carry_gates: assert property (p_carry_gates)
      else $error("Counted with carry input inactive");

   // Any change traces to reset or a non-hold mode at the previous edge;
   // a reset edge may clear the count whatever the selects showed
   property p_edge_only;
      $changed(count_reg)
         |-> ($past(SRST) || $past(mode_now) != decade_pkg::MODE_HOLD);
   endproperty
   a_edge_only: assert property (p_edge_only)
      else $error("Count changed without a counting edge");

   // Terminal count while enabled pulls carry low
   property p_carry_low;
      (!CARRY_IN_N && ((!dir_down && count_reg == decade_pkg::CNT_NINE)
         || (dir_down && count_reg == decade_pkg::CNT_ZERO)))
         |-> !CARRY_OUT_N;
   endproperty
   a_carry_low: assert property (p_carry_low)
      else $error("Carry output not low at terminal count");

   // Away from terminal values the carry stays high
   property p_carry_high;
      (count_reg > decade_pkg::CNT_ZERO
         && count_reg < decade_pkg::CNT_NINE) |-> CARRY_OUT_N;
   endproperty
   a_carry_high: assert property (p_carry_high)
      else $error("Carry output low off terminal count");

   // A preset of nine shows on the carry right after the load
   property p_preset_carry;
      (mode_now == decade_pkg::MODE_PRESET
         && preset_word == decade_pkg::CNT_NINE)
         ##1 (mode_now != decade_pkg::MODE_DOWN && !CARRY_IN_N)
         |-> !CARRY_OUT_N;
   endproperty
   a_preset_carry: assert property (p_preset_carry)
      else $error("Carry output ignores preset value");

   // Out-of-range values leave within one counting edge
   property p_recover;
      (count_reg > decade_pkg::CNT_NINE && !CARRY_IN_N
         && (mode_now == decade_pkg::MODE_UP
         || mode_now == decade_pkg::MODE_DOWN))
         |=> (count_reg <= decade_pkg::CNT_NINE);
   endproperty
   a_recover: assert property (p_recover)
      else $error("Counter stuck outside decimal range");

   // Carry input is part of the counting decision
   property p_carry_counts;
      (mode_now == decade_pkg::MODE_UP && !CARRY_IN_N
         && count_reg <= decade_pkg::CNT_NINE) |=> $changed(count_reg);
   endproperty
   a_carry_counts: assert property (p_carry_counts)
      else $error("Enabled count-up edge left count unchanged");

endmodule : sync_updown_decade_counter

`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, got, exp) begin num_checks++; if ((got) !== (exp)) begin \
   miscompares++; $display("unexpected %s exp %h got %h", nm, exp, got); \
   end end

module tb;
   logic       clk;
   logic       srst;
   logic       sel_a;
   logic       sel_b;
   logic       cin_n;
   logic [3:0] data;
   logic [3:0] model_reg;
   wire  logic [3:0] cnt;
   wire  logic [3:0] tens;
   wire  logic       cout_n;
   int         miscompares;
   int         num_checks;

   sync_updown_decade_counter dut_u (
      .CLK_SYS(clk), .SRST(srst),
      .FUNCTION_SELECT_A(sel_a), .FUNCTION_SELECT_B(sel_b),
      .PRESET_BIT_ZERO(data[0]), .PRESET_BIT_ONE(data[1]),
      .PRESET_BIT_TWO(data[2]), .PRESET_BIT_THREE(data[3]),
      .CARRY_IN_N(cin_n),
      .COUNT_BIT_ZERO(cnt[0]), .COUNT_BIT_ONE(cnt[1]),
      .COUNT_BIT_TWO(cnt[2]), .COUNT_BIT_THREE(cnt[3]),
      .CARRY_OUT_N(cout_n)
   );

   tens_stage tens_u (
      .clk(clk), .srst(srst), .carry_in_n(cout_n), .tens(tens)
   );

   // ------------------------------------------------------------------
   // Clock and reference digit
   // ------------------------------------------------------------------
   always #50 clk = ~clk;

   // Stepped on the design's own edge, so every cycle can be compared
   always @(posedge clk) begin
      if (srst) begin
         model_reg <= decade_pkg::CNT_ZERO;
      end else begin
         case ({sel_a, sel_b})
            2'h0: model_reg <= data;
            2'h1: if (!cin_n) begin
               model_reg <= (model_reg >= decade_pkg::CNT_NINE) ?
                  decade_pkg::CNT_ZERO : model_reg + decade_pkg::CNT_STEP;
            end
            2'h2: if (!cin_n) begin
               model_reg <= (model_reg == decade_pkg::CNT_ZERO ||
                  model_reg > decade_pkg::CNT_NINE) ?
                  decade_pkg::CNT_NINE : model_reg - decade_pkg::CNT_STEP;
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Drivers and scenarios
   // ------------------------------------------------------------------
   // Inputs change just after an edge, so none moves while it is sampled
   task automatic step(input logic a, input logic b, input logic [3:0] d,
                       input logic c);
      logic exp_co;
      @(posedge clk);
      sel_a <= a;
      sel_b <= b;
      data  <= d;
      cin_n <= c;
      @(negedge clk);
      exp_co = !(!cin_n && (({sel_a, sel_b} == 2'h2) ?
         model_reg == decade_pkg::CNT_ZERO : model_reg == decade_pkg::CNT_NINE));
      `CHK("count", cnt, model_reg)
      `CHK("carry out", cout_n, exp_co)
   endtask : step

   // Reset is raised and dropped on rising edges only, held for one edge
   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      step(1'b1, 1'b1, 4'h0, 1'b1);
      `CHK("count after reset", cnt, 4'h0)
   endtask : do_reset

   // Every decimal code loads, and only on the edge after selection
   task automatic t_preset();
      for (int i = 0; i < 10; i++) begin
         step(1'b0, 1'b0, i[3:0], 1'b1);
         step(1'b1, 1'b1, 4'h0, 1'b0);
         `CHK("preset load", cnt, i[3:0])
      end
   endtask : t_preset

   // Two wraps upward, seen by the cascaded stage as two tens
   task automatic t_up();
      do_reset();
      for (int i = 0; i < 20; i++) step(1'b0, 1'b1, 4'h0, 1'b0);
      step(1'b1, 1'b1, 4'h0, 1'b1);
      `CHK("tens after twenty", tens, 4'h2)
   endtask : t_up

   task automatic t_down();
      for (int i = 0; i < 11; i++) step(1'b1, 1'b0, 4'h0, 1'b0);
   endtask : t_down

   // An idle carry input stops both counting modes
   task automatic t_block();
      logic [3:0] held;
      // The first step still shows the last enabled down count
      step(1'b0, 1'b1, 4'h0, 1'b1);
      held = cnt;
      step(1'b1, 1'b0, 4'h0, 1'b1);
      step(1'b1, 1'b1, 4'h0, 1'b0);
      `CHK("blocked count", cnt, held)
   endtask : t_block

   // Codes above nine rejoin the decimal ring in one edge
   task automatic t_recover();
      step(1'b0, 1'b0, 4'hC, 1'b1);
      step(1'b0, 1'b1, 4'h0, 1'b0);
      step(1'b1, 1'b1, 4'h0, 1'b1);
      `CHK("recover upward", cnt, 4'h0)
      step(1'b0, 1'b0, 4'hF, 1'b1);
      step(1'b1, 1'b0, 4'h0, 1'b0);
      step(1'b1, 1'b1, 4'h0, 1'b1);
      `CHK("recover downward", cnt, 4'h9)
   endtask : t_recover

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Whole run is near 66 cycles; this limit leaves ample margin
   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end

   initial begin
      clk = 1'b0;
      srst = 1'b1;
      sel_a = 1'b1;
      sel_b = 1'b1;
      cin_n = 1'b1;
      data = 4'h0;
      miscompares = 0;
      num_checks = 0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_preset();
      t_up();
      t_down();
      t_block();
      t_recover();
      print_verdict();
   end
endmodule : tb

`default_nettype wire

//--- testbench/tens_stage.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------------
// Next cascade stage, counting up only
// ---------------------------------------------------------------------
// Shares the low digit's clock and takes its carry with no gating, so a
// carry that settles late in the cycle would show here as a lost tens.
module tens_stage (
   input  wire logic       clk,        // Shared system clock
   input  wire logic       srst,       // Synchronous reset, high
   input  wire logic       carry_in_n, // Low digit terminal count
   output logic [3:0]      tens        // Tens digit
);
   logic [3:0] tens_reg;

   // Advance on the common edge only while the low digit sits at terminal
   always @(posedge clk) begin
      if (srst) begin
         tens_reg <= 4'h0;
      end else if (!carry_in_n) begin
         tens_reg <= (tens_reg == 4'h9) ? 4'h0 : tens_reg + 4'h1;
      end
   end

   assign tens = tens_reg;
endmodule : tens_stage

`default_nettype wire
